// ---- src/hocs_defs.svh ----
// How it works
// R1: watch one harmonic order, default second
// R2: per-unit or relative mode, per-unit default
// R3: input three-phase or residual one/two
// R4: pick-up when any phase exceeds shared level
// R5: release below 97 percent of setting
// R6: per-unit level 0.05..2.00, default 0.20
// R7: relative level 5.00..200.00 percent, default 20
// R8: settings change live without restart
// R9: forcing overrides state when globally enabled
// R10: condition readout normal/start/trip/blocked
// R11: ratio of measurement to setting readout
// R12: expected operating time readout, 5 ms steps
// R13: signed remaining time while counting
// R14: block sampled each cycle; clear gives start
// R15: block at pick-up gives blocked only
// R16: block after start drops start, releases
// R17: blocker asserts 5 ms before delay ends
// R18: definite-time and inverse-time delays
// R19: on/off events per stage, edge selectable
// R20: resettable start/trip/blocked counters
// R21: twelve-entry circular history on rising events
// R22: record holds stamp, event, currents, group
// R23: front end updates values every 5 ms
// R24: start and trip are level outputs
// Purpose: constants for the harmonic overcurrent stage
// Assumes: magnitudes in 0.01 units, one strobe per 5 ms cycle
// Notes: definitions only
`ifndef HOCS_DEFS_SVH
`define HOCS_DEFS_SVH
`define HOCS_MAG_W 16
`define HOCS_TIME_W 20
`define HOCS_CNT_W 16
`define HOCS_REC_DEPTH 12
`define HOCS_RESET_PCT 97
`define HOCS_PCT_DIV 100
`define HOCS_PU_MIN 16'h0005
`define HOCS_PU_MAX 16'h00C8
`define HOCS_PU_DEF 16'h0014
`define HOCS_REL_MIN 16'h01F4
`define HOCS_REL_MAX 16'h4E20
`define HOCS_REL_DEF 16'h07D0
`define HOCS_CYCLE_MS 5
`define HOCS_PRE20_CYC 4
`define HOCS_PRE200_CYC 40
`define HOCS_HIST_LEN 64
`define HOCS_ORDER_DEF 5'h02
`define HOCS_RATIO_SCALE 100
`endif

// ---- src/hocs_pkg.sv ----
// Purpose: types for the harmonic overcurrent stage
// Assumes: hocs_defs.svh for numbers
// Notes: state codes are the readout codes
package hocs_pkg;
	typedef enum logic [1:0] {HOCS_NORMAL = 2'b00, HOCS_START = 2'b01,
		HOCS_TRIP = 2'b10, HOCS_BLOCKED = 2'b11} hocs_cond_e;
	typedef enum logic [1:0] {HOCS_IN_PHASE = 2'b00, HOCS_IN_RES1 = 2'b01,
		HOCS_IN_RES2 = 2'b10} hocs_input_e;
	typedef enum logic [1:0] {HOCS_EV_BOTH = 2'b00, HOCS_EV_ON = 2'b01,
		HOCS_EV_OFF = 2'b10} hocs_evsel_e;
endpackage

// ---- src/hocs_compare.sv ----
// Purpose: picks the monitored value per phase and compares it
// Assumes: inputs already synchronous, values in 0.01 units
// Notes: purely combinational, feeds the stage sequencer
`timescale 1ns/100ps
`include "hocs_defs.svh"
module hocs_compare #(
	parameter int MW = `HOCS_MAG_W
) (
	input wire logic [2:0][MW-1:0] harm_mag, // selected harmonic per channel
	input wire logic [2:0][MW-1:0] fund_mag, // fundamental per channel
	input wire logic [MW-1:0] res1_harm, // residual one harmonic
	input wire logic [MW-1:0] res1_fund, // residual one fundamental
	input wire logic [MW-1:0] res2_harm, // residual two harmonic
	input wire logic [MW-1:0] res2_fund, // residual two fundamental
	input wire hocs_pkg::hocs_input_e in_sel, // input choice
	input wire logic rel_mode, // relative monitoring
	input wire logic [MW-1:0] level, // active pick-up level
	input wire logic picked, // currently picked up
	output logic over, // pick-up condition
	output logic [2:0] phase_over, // phases over level
	output logic [MW-1:0] meas_max // largest monitored value
);
	import hocs_pkg::*;
	logic [2:0][MW-1:0] mon;
	logic [MW+7:0] rel_thr;
	// relative value is harmonic over fundamental in 0.01 percent
	function automatic logic [MW-1:0] monitored(input logic [MW-1:0] h, input logic [MW-1:0] f,
		input logic rel);
		logic [MW+15:0] q;
		q = '0;
		if (!rel) begin
			monitored = h; // see R2
		end else if (f == '0) begin
			monitored = '0;
		end else begin
			q = ({16'h0000, h} * 32'h0000_2710) / {16'h0000, f};
			monitored = (q > {16'h0000, {MW{1'b1}}}) ? {MW{1'b1}} : q[MW-1:0];
		end
	endfunction
	// channel choice and shared threshold with 97 percent release
	always_comb begin
		mon[0] = monitored(harm_mag[0], fund_mag[0], rel_mode); // see R3
		mon[1] = monitored(harm_mag[1], fund_mag[1], rel_mode);
		mon[2] = monitored(harm_mag[2], fund_mag[2], rel_mode);
		if (in_sel == HOCS_IN_RES1) begin
			mon = '0;
			mon[0] = monitored(res1_harm, res1_fund, rel_mode);
		end else if (in_sel == HOCS_IN_RES2) begin
			mon = '0;
			mon[0] = monitored(res2_harm, res2_fund, rel_mode);
		end
		rel_thr = ({8'h00, level} * (MW+8)'(`HOCS_RESET_PCT)) / (MW+8)'(`HOCS_PCT_DIV); // see R5
		meas_max = '0;
		for (int i = 0; i < 3; i++) begin
			if (picked)
				phase_over[i] = {8'h00, mon[i]} >= rel_thr; // see R5
			else
				phase_over[i] = mon[i] > level; // see R4
			if (mon[i] > meas_max)
				meas_max = mon[i];
		end
		over = |phase_over; // see R4
	end
endmodule

// ---- src/hocs_history.sv ----
// Purpose: twelve-entry circular record store
// Assumes: one write strobe per event
// Notes: readout by index, 0 is newest
`timescale 1ns/100ps
`include "hocs_defs.svh"
module hocs_history #(
	parameter int DEPTH = `HOCS_REC_DEPTH,
	parameter int RW = 128
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic ce, // clock enable
	input wire logic wr, // store a record
	input wire logic [RW-1:0] wdata, // record
	input wire logic [3:0] rd_idx, // age of record to read
	output logic [RW-1:0] rdata, // record read
	output logic [3:0] fill // records held
);
	typedef struct packed {
		logic [3:0] wp;
		logic [3:0] cnt;
		logic [RW-1:0] rd;
	} hocs_hist_s;
	hocs_hist_s st_ff, nxt_st;
	logic [RW-1:0] mem [DEPTH];
	logic [4:0] pos;
	// oldest entry overwritten when full
	always_comb begin
		nxt_st = st_ff;
		pos = {1'b0, st_ff.wp} + 5'(DEPTH) - 5'd1 - {1'b0, rd_idx};
		if (pos >= 5'(DEPTH))
			pos = pos - 5'(DEPTH);
		nxt_st.rd = (rd_idx < st_ff.cnt) ? mem[pos[3:0]] : '0;
		if (wr) begin
			nxt_st.wp = (st_ff.wp == 4'(DEPTH - 1)) ? 4'h0 : st_ff.wp + 4'h1; // see R21
			if (st_ff.cnt != 4'(DEPTH))
				nxt_st.cnt = st_ff.cnt + 4'h1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end
	// storage has no reset, only valid entries are readable
	always_ff @(posedge clk) begin
		if (ce && wr)
			mem[st_ff.wp] <= wdata; // see R22
	end
	assign rdata = st_ff.rd;
	assign fill = st_ff.cnt;
endmodule

// ---- src/hocs_stage.sv ----
// Purpose: one harmonic overcurrent stage
// Assumes: cycle strobe every 5 ms from the front end
// Notes: instantiate four times; events stay per stage
`timescale 1ns/100ps
`include "hocs_defs.svh"
module hocs_stage #(
	parameter int MW = `HOCS_MAG_W,
	parameter int TW = `HOCS_TIME_W,
	parameter int CW = `HOCS_CNT_W
) (
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire logic cycle_stb, // new measurement set
	input wire logic [2:0][MW-1:0] three_phase_input, // harmonic per phase
	input wire logic [2:0][MW-1:0] fund_in, // fundamental per phase
	input wire logic [MW-1:0] residual_input_one, // residual one harmonic
	input wire logic [MW-1:0] res1_fund, // residual one fundamental
	input wire logic [MW-1:0] residual_input_two, // residual two harmonic
	input wire logic [MW-1:0] res2_fund, // residual two fundamental
	input wire logic [4:0] harm_order, // harmonic order in use
	input wire hocs_pkg::hocs_input_e in_sel, // input selection
	input wire logic rel_mode, // relative monitoring
	input wire logic [MW-1:0] per_unit_pickup_level, // level, 0.01 In
	input wire logic [MW-1:0] relative_pickup_level, // level, 0.01 percent
	input wire logic idmt_mode, // inverse time instead of definite
	input wire logic [TW-1:0] op_delay, // operate delay, 5 ms steps
	input wire logic [TW-1:0] rel_delay, // release delay, 5 ms steps
	input wire logic [2:0] setting_group, // group in use
	input wire logic block_in, // blocking matrix input
	input wire logic force_en, // global forcing enable
	input wire hocs_pkg::hocs_cond_e force_state, // forced condition
	input wire hocs_pkg::hocs_evsel_e event_sel, // edges to report
	input wire logic cnt_clr, // clear counters, pulse
	input wire logic [31:0] timestamp, // time of day
	input wire logic [3:0] rec_idx, // history read index
	output logic start_out, // start level
	output logic trip_out, // trip level
	output logic blocked_out, // blocked level
	output hocs_pkg::hocs_cond_e condition, // condition readout
	output logic [23:0] ratio_now, // meas over setting, 0.01
	output logic [TW-1:0] exp_op_time, // expected time, 5 ms
	output logic signed [TW:0] time_to_trip, // remaining time, 5 ms
	output logic event_vld, // event pulse
	output logic [2:0] event_id, // which edge
	output logic [31:0] event_time, // event stamp
	output logic [CW-1:0] start_cnt, // start count
	output logic [CW-1:0] trip_cnt, // trip count
	output logic [CW-1:0] block_cnt, // blocked count
	output logic [127:0] rec_data, // history record
	output logic [3:0] rec_fill, // records held
	output logic [4:0] order_used // harmonic order echoed
);
	import hocs_pkg::*;
	localparam int RW = 128;
	typedef struct packed {
		logic [1:0] blk_sync;
		logic [1:0] stb_sync;
		logic stb_prev;
		hocs_cond_e cond;
		logic start;
		logic trip;
		logic blocked;
		logic [TW-1:0] op_cnt;
		logic [TW-1:0] rel_cnt;
		logic [TW-1:0] exp_t;
		logic signed [TW:0] ttt;
		logic [23:0] ratio;
		logic [MW-1:0] meas;
		logic [5:0] hp;
		logic [MW-1:0] cur_pre20;
		logic [MW-1:0] cur_pre200;
		logic [2:0] phases;
		logic ev_vld;
		logic [2:0] ev_id;
		logic [31:0] ev_t;
		logic [CW-1:0] c_st;
		logic [CW-1:0] c_tr;
		logic [CW-1:0] c_bl;
		logic rec_wr;
		logic [RW-1:0] rec;
		logic [4:0] order;
		logic [2:0] lvl;
	} hocs_st_s;
	hocs_st_s st_ff, nxt_st;
	logic [MW-1:0] hist_mem [`HOCS_HIST_LEN];
	logic [MW-1:0] level;
	logic over;
	logic [2:0] phase_over;
	logic [MW-1:0] meas_max;
	logic tick;
	logic blk;
	logic [TW-1:0] op_target;
	logic [2:0] ev_code;
	logic ev_any;
	logic fst, ftr, fbl;
	logic [RW-1:0] rdata;
	logic [3:0] fill;
	// clamp settings into their documented span; changes act at once
	function automatic logic [MW-1:0] clamp(input logic [MW-1:0] v, input logic [MW-1:0] lo,
		input logic [MW-1:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	// event edge filter keeps on, off or both
	function automatic logic keep_ev(input hocs_evsel_e sel, input logic on);
		keep_ev = (sel == HOCS_EV_BOTH) || (on ? (sel == HOCS_EV_ON) : (sel == HOCS_EV_OFF));
	endfunction
	always_comb begin
		if (rel_mode)
			level = clamp(relative_pickup_level, `HOCS_REL_MIN, `HOCS_REL_MAX); // see R7
		else
			level = clamp(per_unit_pickup_level, `HOCS_PU_MIN, `HOCS_PU_MAX); // see R6
	end
	hocs_compare #(.MW(MW)) u_cmp (
		.harm_mag(three_phase_input),
		.fund_mag(fund_in),
		.res1_harm(residual_input_one),
		.res1_fund(res1_fund),
		.res2_harm(residual_input_two),
		.res2_fund(res2_fund),
		.in_sel(in_sel),
		.rel_mode(rel_mode),
		.level(level),
		.picked(st_ff.start | st_ff.trip | st_ff.blocked),
		.over(over),
		.phase_over(phase_over),
		.meas_max(meas_max)
	);
	hocs_history #(.DEPTH(`HOCS_REC_DEPTH), .RW(RW)) u_hist (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.wr(st_ff.rec_wr),
		.wdata(st_ff.rec),
		.rd_idx(rec_idx),
		.rdata(rdata),
		.fill(fill)
	);
	assign tick = st_ff.stb_sync[1] & ~st_ff.stb_prev;
	assign blk = st_ff.blk_sync[1];
	// main sequencer, advances once per program cycle
	always_comb begin
		nxt_st = st_ff;
		op_target = '0;
		ev_code = 3'h0;
		ev_any = 1'b0;
		nxt_st.blk_sync = {st_ff.blk_sync[0], block_in};
		nxt_st.stb_sync = {st_ff.stb_sync[0], cycle_stb};
		nxt_st.stb_prev = st_ff.stb_sync[1];
		nxt_st.ev_vld = 1'b0;
		nxt_st.rec_wr = 1'b0;
		nxt_st.order = (harm_order == 5'h00) ? `HOCS_ORDER_DEF : harm_order; // see R1
		if (tick) begin
			nxt_st.meas = meas_max;
			nxt_st.hp = (st_ff.hp == 6'(`HOCS_HIST_LEN - 1)) ? 6'h00 : st_ff.hp + 6'h01;
			nxt_st.cur_pre20 = hist_mem[6'(st_ff.hp - 6'(`HOCS_PRE20_CYC))]; // see R22
			nxt_st.ratio = 24'(({8'h00, meas_max} * 24'(`HOCS_RATIO_SCALE))
				/ {8'h00, level}); // see R11
			// inverse time scales the delay by setting over measurement
			if (idmt_mode && meas_max > level)
				op_target = TW'(({4'h0, op_delay} * (TW+4)'(level)) / (TW+4)'(meas_max)); // see R18
			else
				op_target = op_delay; // see R18
			nxt_st.exp_t = op_target; // see R12
			if (over && !st_ff.trip && !st_ff.blocked && !st_ff.start) begin
				nxt_st.rel_cnt = '0;
				nxt_st.phases = phase_over;
				nxt_st.cur_pre200 = hist_mem[6'(st_ff.hp - 6'(`HOCS_PRE200_CYC))];
				if (blk)
					nxt_st.blocked = 1'b1; // see R15
				else begin
					nxt_st.start = 1'b1; // see R14
					nxt_st.op_cnt = '0;
				end
			end else if (st_ff.start && blk) begin
				nxt_st.start = 1'b0; // see R16
				nxt_st.blocked = 1'b1;
			end else if (st_ff.start && over) begin
				nxt_st.op_cnt = st_ff.op_cnt + TW'(1);
				// a blocker seen on the tick that would trip still stops this
				if (st_ff.op_cnt + TW'(1) >= op_target)
					nxt_st.trip = 1'b1; // see R17
			end else if ((st_ff.start || st_ff.trip || st_ff.blocked) && !over) begin
				nxt_st.rel_cnt = st_ff.rel_cnt + TW'(1);
				if (st_ff.rel_cnt + TW'(1) >= rel_delay) begin
					nxt_st.start = 1'b0; // see R16
					nxt_st.trip = 1'b0;
					nxt_st.blocked = 1'b0;
					nxt_st.rel_cnt = '0;
				end
			end
			if (nxt_st.trip)
				nxt_st.start = 1'b0;
			nxt_st.ttt = nxt_st.start ? $signed({1'b0, op_target}) - $signed({1'b0, nxt_st.op_cnt})
				: '0; // see R13
		end
		// forcing overrides the computed condition, see R9
		fst = force_en ? (force_state == HOCS_START) : nxt_st.start;
		ftr = force_en ? (force_state == HOCS_TRIP) : nxt_st.trip;
		fbl = force_en ? (force_state == HOCS_BLOCKED) : nxt_st.blocked;
		if (ftr)
			nxt_st.cond = HOCS_TRIP; // see R10
		else if (fbl)
			nxt_st.cond = HOCS_BLOCKED;
		else if (fst)
			nxt_st.cond = HOCS_START;
		else
			nxt_st.cond = HOCS_NORMAL;
		// edges of the reported levels become events, see R19
		if (fst != (st_ff.cond == HOCS_START)) begin
			ev_code = fst ? 3'h0 : 3'h1;
			ev_any = 1'b1;
		end else if (ftr != (st_ff.cond == HOCS_TRIP)) begin
			ev_code = ftr ? 3'h2 : 3'h3;
			ev_any = 1'b1;
		end else if (fbl != (st_ff.cond == HOCS_BLOCKED)) begin
			ev_code = fbl ? 3'h4 : 3'h5;
			ev_any = 1'b1;
		end
		if (ev_any && keep_ev(event_sel, ~ev_code[0])) begin
			nxt_st.ev_vld = 1'b1; // see R19
			nxt_st.ev_id = ev_code;
			nxt_st.ev_t = timestamp;
		end
		if (ev_any && !ev_code[0]) begin
			nxt_st.rec_wr = 1'b1; // see R21
			nxt_st.rec = {timestamp, 5'h00, ev_code, nxt_st.phases, 2'b00, nxt_st.cur_pre20,
				nxt_st.meas, nxt_st.cur_pre200, 3'h0, setting_group, nxt_st.ttt[TW:0],
				8'h00}; // see R22
		end
		// counters: set beats clear so no occurrence is lost
		if (cnt_clr) begin
			nxt_st.c_st = '0; // see R20
			nxt_st.c_tr = '0;
			nxt_st.c_bl = '0;
		end
		if (ev_any && ev_code == 3'h0)
			nxt_st.c_st = (cnt_clr ? '0 : st_ff.c_st) + CW'(1);
		if (ev_any && ev_code == 3'h2)
			nxt_st.c_tr = (cnt_clr ? '0 : st_ff.c_tr) + CW'(1);
		if (ev_any && ev_code == 3'h4)
			nxt_st.c_bl = (cnt_clr ? '0 : st_ff.c_bl) + CW'(1);
		// one edge reported per clock; only after a start fall do the rest follow next clock
		if (ev_any && ev_code[2:1] == 2'b00)
			nxt_st.cond = fst ? HOCS_START : (st_ff.cond == HOCS_START ? HOCS_NORMAL : st_ff.cond);
		// levels registered so no decode sits behind the pins
		nxt_st.lvl = {nxt_st.cond == HOCS_BLOCKED, nxt_st.cond == HOCS_TRIP,
			nxt_st.cond == HOCS_START}; // see R24
	end
	// state register, settings are read live (see R8)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.order <= `HOCS_ORDER_DEF;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end
	// measurement history for pre-fault currents
	always_ff @(posedge clk) begin
		if (ce && tick)
			hist_mem[st_ff.hp] <= meas_max;
	end
	// level outputs held while the condition lasts, see R24
	assign start_out = st_ff.lvl[0];
	assign trip_out = st_ff.lvl[1];
	assign blocked_out = st_ff.lvl[2];
	assign condition = st_ff.cond;
	assign ratio_now = st_ff.ratio;
	assign exp_op_time = st_ff.exp_t;
	assign time_to_trip = st_ff.ttt;
	assign event_vld = st_ff.ev_vld;
	assign event_id = st_ff.ev_id;
	assign event_time = st_ff.ev_t;
	assign start_cnt = st_ff.c_st;
	assign trip_cnt = st_ff.c_tr;
	assign block_cnt = st_ff.c_bl;
	assign rec_data = rdata;
	assign rec_fill = fill;
	assign order_used = st_ff.order;
endmodule

// ---- test/hocs_stage_sva.sv ----
// Purpose: port checks for the harmonic stage
// Assumes: ce held high, events not queued behind older edges
// Notes: bound below to every hocs_stage
`timescale 1ns/100ps
module hocs_stage_chk #(
	parameter int CW = 16
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic force_en, // forcing on
	input wire hocs_pkg::hocs_cond_e force_state, // forced state
	input wire logic cnt_clr, // counter clear
	input wire logic [4:0] harm_order, // order asked
	input wire hocs_pkg::hocs_evsel_e event_sel, // edge choice
	input wire logic start_out, // start level
	input wire logic trip_out, // trip level
	input wire logic blocked_out, // blocked level
	input wire hocs_pkg::hocs_cond_e condition, // state readout
	input wire logic event_vld, // event pulse
	input wire logic [2:0] event_id, // event kind
	input wire logic [CW-1:0] start_cnt, // starts
	input wire logic [CW-1:0] trip_cnt, // trips
	input wire logic [CW-1:0] block_cnt, // blocks
	input wire logic [4:0] order_used // order echo
);
	import hocs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// forcing may pass a synchroniser, so allow a few clocks
	sequence s_forced;
		(force_en && $stable(force_state)) [*4];
	endsequence
	// a clean start edge, no other edge competing for the event slot
	sequence s_start_rise;
		$rose(start_out) && !force_en && !$past(force_en) && !$fell(trip_out)
			&& !$fell(blocked_out);
	endsequence
	sequence s_clear_quiet;
		(cnt_clr && !start_out && !trip_out && !blocked_out) [*3];
	endsequence
	AST_FORCE: assert property (s_forced |-> condition == force_state)
		else $error("forced state not shown");
	AST_BLOCKED_QUIET: assert property (!force_en && condition == HOCS_BLOCKED |->
		blocked_out && !start_out && !trip_out) else $error("blocked state drives start");
	AST_NORMAL_QUIET: assert property (!force_en && condition == HOCS_NORMAL |->
		!start_out && !trip_out && !blocked_out) else $error("normal state drives a level");
	AST_TRIP_LEVEL: assert property ($rose(trip_out) && !force_en |=> trip_out [*2])
		else $error("trip level not held");
	// start is withdrawn one clock before the trip edge is shown
	AST_TRIP_AFTER_START: assert property ($rose(trip_out) && !force_en &&
		!$past(force_en) |-> $past(start_out, 2)) else $error("trip without prior start");
	AST_START_EVENT: assert property (s_start_rise ##0 event_sel != HOCS_EV_OFF |->
		event_vld && event_id == 3'h0) else $error("start edge gave no event");
	AST_START_COUNT: assert property (s_start_rise ##0 !cnt_clr |->
		start_cnt == $past(start_cnt) + 1'b1) else $error("start count not advanced");
	AST_CLEAR: assert property (s_clear_quiet |-> ~|start_cnt && ~|trip_cnt && ~|block_cnt)
		else $error("counters not cleared");
	AST_ORDER_DEFAULT: assert property (harm_order == 5'h00 ##1 harm_order == 5'h00 |->
		order_used == 5'h02) else $error("default order not used");
endmodule
bind hocs_stage hocs_stage_chk #(.CW(CW)) u_chk (.clk(clk), .rst(rst), .force_en(force_en),
	.force_state(force_state), .cnt_clr(cnt_clr), .harm_order(harm_order),
	.event_sel(event_sel), .start_out(start_out), .trip_out(trip_out),
	.blocked_out(blocked_out), .condition(condition), .event_vld(event_vld),
	.event_id(event_id), .start_cnt(start_cnt), .trip_cnt(trip_cnt),
	.block_cnt(block_cnt), .order_used(order_used));

// ---- test/hocs_front_model.sv ----
// Purpose: measurement front end feeding the stage
// Assumes: PER clocks stand for one 5 ms cycle
// Notes: new set published one clock before the strobe
`timescale 1ns/100ps
module hocs_front_model #(
	parameter int PER = 16
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic [4:0][15:0] h_want, // harmonics: 3 phases, res1, res2
	input wire logic [4:0][15:0] f_want, // fundamentals, same order
	output logic cycle_stb, // new cycle strobe
	output logic [2:0][15:0] ph_h, // phase harmonics
	output logic [2:0][15:0] ph_f, // phase fundamentals
	output logic [15:0] r1h, // residual one harmonic
	output logic [15:0] r1f, // residual one fundamental
	output logic [15:0] r2h, // residual two harmonic
	output logic [15:0] r2f // residual two fundamental
);
	int cnt;
	// values only move between strobes so a tick never sees a half set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			cycle_stb <= 1'b0;
			{ph_h, ph_f, r1h, r1f, r2h, r2f} <= '0;
		end else begin
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
			cycle_stb <= (cnt < 2);
			if (cnt == PER - 1) begin
				ph_h <= h_want[2:0];
				ph_f <= f_want[2:0];
				{r1h, r2h} <= {h_want[3], h_want[4]};
				{r1f, r2f} <= {f_want[3], f_want[4]};
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for one harmonic stage
// Assumes: definite time, operate 4 cycles, release 1 cycle
// Notes: model tracks state, counters and record fill
`timescale 1ns/100ps
`define HOCS_CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module tb;
	import hocs_pkg::*;
	logic clk, rst, cnt_clr, block_in, force_en, rel_mode, stb, s_o, t_o, b_o;
	logic [4:0][15:0] h_want, f_want;
	logic [2:0][15:0] ph_h, ph_f;
	logic [15:0] r1h, r1f, r2h, r2f, pu_lvl, rel_lvl, cs, ct, cb;
	logic [4:0] harm_order, ord_out;
	logic [2:0] grp;
	logic [31:0] tstamp;
	logic [3:0] rec_idx, fill;
	logic [23:0] ratio;
	logic [19:0] eot;
	hocs_input_e in_sel;
	hocs_evsel_e evs;
	hocs_cond_e force_state, cond, m_cond;
	int num_errors, samples_checked, m_start, m_trip, m_block, m_rec, m_meas, m_lvl, ph, ch;
	int ord_tab[12] = '{2, 3, 4, 5, 6, 7, 9, 11, 13, 15, 17, 19};
	hocs_front_model #(.PER(16)) u_front (.clk(clk), .rst(rst), .h_want(h_want),
		.f_want(f_want), .cycle_stb(stb), .ph_h(ph_h), .ph_f(ph_f), .r1h(r1h), .r1f(r1f),
		.r2h(r2h), .r2f(r2f));
	hocs_stage dut (.clk(clk), .rst(rst), .ce(1'b1), .cycle_stb(stb), .three_phase_input(ph_h),
		.fund_in(ph_f), .residual_input_one(r1h), .res1_fund(r1f), .residual_input_two(r2h),
		.res2_fund(r2f), .harm_order(harm_order), .in_sel(in_sel), .rel_mode(rel_mode),
		.per_unit_pickup_level(pu_lvl), .relative_pickup_level(rel_lvl), .idmt_mode(1'b0),
		.op_delay(20'h00004), .rel_delay(20'h00001), .setting_group(grp), .block_in(block_in),
		.force_en(force_en), .force_state(force_state), .event_sel(evs),
		.cnt_clr(cnt_clr), .timestamp(tstamp), .rec_idx(rec_idx), .start_out(s_o),
		.trip_out(t_o), .blocked_out(b_o), .condition(cond), .ratio_now(ratio),
		.exp_op_time(eot), .time_to_trip(), .event_vld(), .event_id(), .event_time(),
		.start_cnt(cs), .trip_cnt(ct), .block_cnt(cb), .rec_data(), .rec_fill(fill),
		.order_used(ord_out));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// free-running stamp so records differ
	always @(posedge clk) tstamp <= tstamp + 32'h1;
	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// waits n measurement cycles, bounded, then lets the result settle
	task automatic ticks(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (stb !== 1'b0 && k < 100) begin @(posedge clk); k++; end
			while (stb !== 1'b1 && k < 100) begin @(posedge clk); k++; end
			if (k >= 100) begin
				num_errors++;
				$display("ERROR %0t: no measurement cycle", $time);
				final_report();
			end
			grp <= 3'($urandom % 8);
			rec_idx <= 4'($urandom % 12);
			evs <= hocs_evsel_e'($urandom % 3);
		end
		repeat (6) @(posedge clk);
	endtask
	// one channel at h, every other channel at base
	task automatic set_meas(input int p, input int h, input int base);
		@(posedge clk);
		for (int i = 0; i < 5; i++) h_want[i] <= 16'((i == p) ? h : base);
	endtask
	// model: each new non-normal state is one rising event and one record
	task automatic expect_cond(input hocs_cond_e c, input int meas);
		if (c != m_cond && c != HOCS_NORMAL) m_rec++;
		if (c == HOCS_START && m_cond != HOCS_START) m_start++;
		if (c == HOCS_TRIP && m_cond != HOCS_TRIP) m_trip++;
		if (c == HOCS_BLOCKED && m_cond != HOCS_BLOCKED) m_block++;
		m_cond = c;
		m_meas = meas;
		#1;
		`HOCS_CHECK(cond, m_cond)
		`HOCS_CHECK(b_o, m_cond == HOCS_BLOCKED)
		`HOCS_CHECK(s_o, m_cond == HOCS_START)
		`HOCS_CHECK(t_o, m_cond == HOCS_TRIP)
		`HOCS_CHECK({cs, ct, cb}, {16'(m_start), 16'(m_trip), 16'(m_block)})
		`HOCS_CHECK(fill, 4'((m_rec > 12) ? 12 : m_rec))
		`HOCS_CHECK(ratio, 24'(m_meas * 100 / m_lvl))
	endtask
	initial begin
		{rst, cnt_clr, block_in, force_en, rel_mode, harm_order, grp, rec_idx} = '0;
		rst = 1'b1;
		tstamp = '0;
		in_sel = HOCS_IN_PHASE;
		force_state = HOCS_NORMAL;
		m_cond = HOCS_NORMAL;
		evs = HOCS_EV_BOTH;
		{pu_lvl, rel_lvl} = {16'h0064, 16'h09C4};
		h_want = '0;
		for (int i = 0; i < 5; i++) f_want[i] = 16'h0064;
		{num_errors, samples_checked, m_start, m_trip, m_block, m_rec, m_meas} = '0;
		m_lvl = 100;
		void'($urandom(32'h2647A302));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`HOCS_CHECK(ord_out, 5'h02)
		expect_cond(HOCS_NORMAL, 0);
		@(posedge clk);
		harm_order <= 5'(ord_tab[$urandom % 12]);
		ph = $urandom % 3;
		set_meas(ph, 101, 50);
		ticks(2);
		expect_cond(HOCS_START, 101);
		`HOCS_CHECK(ord_out, harm_order)
		`HOCS_CHECK(eot, 20'h00004)
		set_meas(ph, 97, 50);
		ticks(8);
		expect_cond(HOCS_TRIP, 97);
		set_meas(ph, 96, 50);
		ticks(4);
		expect_cond(HOCS_NORMAL, 96);
		set_meas(ph, 100, 50);
		ticks(4);
		expect_cond(HOCS_NORMAL, 100);
		@(posedge clk);
		block_in <= 1'b1;
		set_meas(ph, 150, 50);
		ticks(3);
		expect_cond(HOCS_BLOCKED, 150);
		set_meas(ph, 0, 50);
		ticks(3);
		block_in <= 1'b0;
		expect_cond(HOCS_NORMAL, 50);
		// relative mode over each input choice, others kept low
		@(posedge clk);
		rel_mode <= 1'b1;
		m_lvl = 2500;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			in_sel <= hocs_input_e'(s);
			ch = (s == 0) ? $urandom % 3 : s + 2;
			set_meas(ch, 30, 5);
			ticks(2);
			expect_cond(HOCS_START, 3000);
			set_meas(ch, 10, 10);
			ticks(4);
			expect_cond(HOCS_NORMAL, 1000);
		end
		// live level change above the span clamps to 2.00 and releases
		@(posedge clk);
		rel_mode <= 1'b0;
		in_sel <= HOCS_IN_PHASE;
		m_lvl = 100;
		set_meas(ph, 150, 50);
		ticks(2);
		expect_cond(HOCS_START, 150);
		@(posedge clk);
		pu_lvl <= 16'h00FA;
		m_lvl = 200;
		ticks(4);
		expect_cond(HOCS_NORMAL, 150);
		@(posedge clk);
		pu_lvl <= 16'h0064;
		m_lvl = 100;
		ticks(2);
		expect_cond(HOCS_START, 150);
		@(posedge clk);
		block_in <= 1'b1;
		ticks(6);
		#1;
		`HOCS_CHECK({s_o, t_o}, 2'b00)
		expect_cond(HOCS_BLOCKED, 150);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			force_en <= 1'b1;
			force_state <= hocs_cond_e'(s);
			repeat (6) @(posedge clk);
			#1;
			`HOCS_CHECK(cond, hocs_cond_e'(s))
		end
		@(posedge clk);
		{force_en, block_in} <= '0;
		set_meas(ph, 0, 0);
		ticks(3);
		cnt_clr <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		`HOCS_CHECK({cs, ct, cb}, 48'h0)
		final_report();
	end
endmodule
